/* src/module_sideband_control.sv */
`timescale 1ns/1ns
// Function
// [RULE_01] Selected module answers the two-wire bus.
// [RULE_02] Deselected module ignores all bus traffic.
// [RULE_03] Undriven select input reads as deselected.
// [RULE_04] Long reset low restores every default.
// [RULE_05] Reset interval starts at reset release.
// [RULE_06] Host ignores status during reset interval.
// [RULE_07] Completion raises attention, not-ready cleared.
// [RULE_08] Power-up posts completion without reset pulse.
// [RULE_09] Low-power request enters reduced-power state.
// [RULE_10] Presence output held low while inserted.
// [RULE_11] Attention low reports fault or critical status.
// [RULE_12] Host reads bus to find interrupt cause.
// [RULE_13] Attention only pulled low or released.
// [RULE_14] Host reads flag field after attention.
// [RULE_15] Flag bytes 3 to 21 are read-only.
// [RULE_16] Short reset pulses change no setting.
module module_sideband_control
    import sideband_pkg::*;
#(
    parameter int INIT_CYCLES = INIT_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       clk_en,
    input  wire logic       bus_select_n_pin,
    input  wire logic       bus_select_driven,
    input  wire logic       module_reset_n,
    input  wire logic       low_power_request,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       core_sda_low,
    output twi_lines_t      core_lines,
    input  wire logic [7:0] core_addr,
    input  wire logic       core_write,
    output logic            core_write_ok,
    input  wire logic       fault_event,
    input  wire logic       attention_ack,
    output logic            attention_n_out,
    output logic            attention_n_oe,
    output logic            present_n_out,
    output logic            present_n_oe,
    output logic            reduced_power,
    output logic            data_not_ready,
    output logic            settings_clear
);

    // ========================================================
    // Pin capture
    // ========================================================
    // [RULE_03] select pulled up
    // With no host drive the select line floats high.
    wire select_level = bus_select_driven ? bus_select_n_pin : 1'b1;

    // Synchronised pin levels.
    logic [PIN_SYNC_W-1:0] pin_raw;
    logic [PIN_SYNC_W-1:0] pin_syn;
    assign pin_raw = {select_level, module_reset_n, low_power_request,
                      scl_in, sda_in};

    // Every pin passes two flip-flops before use.
    pin_sync #(
        .W       (PIN_SYNC_W),
        .RST_VAL (PIN_SYNC_RST)
    ) u_pin_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clk_en  (clk_en),
        .pins    (pin_raw),
        .synced  (pin_syn)
    );

    // Named synchronised levels.
    wire sel_n_s  = pin_syn[4];
    wire reset_s  = pin_syn[3];
    wire lp_s     = pin_syn[2];
    wire scl_s    = pin_syn[1];
    wire sda_s    = pin_syn[0];

    // ========================================================
    // Reset pulse qualification
    // ========================================================
    // Qualified hold and its release pulse.
    logic reset_held;
    logic reset_release;

    reset_qualifier u_reset_qualifier (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .level_n  (reset_s),
        .held     (reset_held),
        .released (reset_release)
    );

    // ========================================================
    // Reset sequencer
    // ========================================================
    // Current state, interval timer and their next values.
    seq_state_t             state;
    seq_state_t             next_state;
    logic [INIT_CNT_W-1:0]  timer;
    logic [INIT_CNT_W-1:0]  next_timer;

    // Last cycle of the reset execution interval.
    wire init_done = (state == ST_INIT) &&
                     (timer == INIT_CNT_W'(INIT_CYCLES - 1));
    // Completion of reset, one cycle.
    wire completion = init_done && !reset_held;

    // Picks the next state; a qualified hold always wins.
    always_comb begin
        next_state = state;
        next_timer = timer;
        case (state)
            // Counting out the interval.
            ST_INIT: begin
                next_timer = timer + 1'b1;
                if (init_done) begin
                    next_state = ST_READY;
                end
            end
            // Normal operation.
            ST_READY: begin
                next_timer = '0;
            end
            // [RULE_05] interval starts on release
            ST_HELD: begin
                next_timer = '0;
                if (reset_release) begin
                    next_state = ST_INIT;
                end
            end
            // Unused code falls back to a fresh interval.
            default: begin
                next_state = ST_INIT;
                next_timer = '0;
            end
        endcase
        if (reset_held) begin
            next_state = ST_HELD;
            next_timer = '0;
        end
    end

    // [RULE_08] power-up starts interval
    // Reset leaves the sequencer counting out a power-up interval.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= ST_INIT;
            timer <= '0;
        end else if (clk_en) begin
            state <= next_state;
            timer <= next_timer;
        end
    end

    // ========================================================
    // Status and settings reset
    // ========================================================
    // [RULE_04] complete reset of settings
    // The clear level stands for the whole hold; status shows
    // not-ready until the interval has run out.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            settings_clear <= 1'b1;
            data_not_ready <= 1'b1;
        end else if (clk_en) begin
            settings_clear <= (next_state == ST_HELD);
            data_not_ready <= (next_state != ST_READY);
        end
    end

    // ========================================================
    // Attention flag
    // ========================================================
    // Sticky attention; a set in the clearing cycle wins.
    logic attention;
    // [RULE_07] completion raises attention
    // [RULE_11] fault raises attention
    wire attention_set = completion ||
                         (fault_event && state == ST_READY &&
                          !reset_held);
    wire next_attention = reset_held ? 1'b0 :
                          (attention_set ||
                           (attention && !attention_ack));

    // Holds the attention request until the host acknowledges it.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            attention <= 1'b0;
        end else if (clk_en) begin
            attention <= next_attention;
        end
    end

    // [RULE_13] open-drain attention
    // The pin is only pulled low or released, never driven high.
    assign attention_n_out = 1'b0;
    assign attention_n_oe  = attention;

    // [RULE_10] presence held low
    // An inserted module always grounds the presence line.
    assign present_n_out = 1'b0;
    assign present_n_oe  = 1'b1;

    // ========================================================
    // Low power
    // ========================================================
    // [RULE_09] reduced power follows request
    // Follows the synchronised request level.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reduced_power <= 1'b0;
        end else if (clk_en) begin
            reduced_power <= lp_s;
        end
    end

    // ========================================================
    // Two-wire bus gating
    // ========================================================
    // The module takes part in bus traffic only while selected.
    wire selected = !sel_n_s;

    // [RULE_01] selected passes bus
    // [RULE_02] deselected sees idle bus
    // A deselected core sees an idle bus and never drives data.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            core_lines <= '{scl: 1'b1, sda: 1'b1};
            sda_oe     <= 1'b0;
        end else if (clk_en) begin
            core_lines <= selected ? twi_lines_t'{scl: scl_s, sda: sda_s}
                                   : twi_lines_t'{scl: 1'b1, sda: 1'b1};
            sda_oe     <= selected && core_sda_low;
        end
    end

    // Data is open drain: only ever pulled low.
    assign sda_out = 1'b0;

    // [RULE_15] flag field read-only
    // Writes into the flag bytes are refused.
    wire in_flags = (core_addr >= FLAG_FIRST) && (core_addr <= FLAG_LAST);
    assign core_write_ok = core_write && !in_flags;

    // ========================================================
    // Checks
    // ========================================================
    a_select_pass: assert property ( // [RULE_01]
        @(posedge sys_clk) disable iff (rst)
        clk_en && selected |=> core_lines.scl == $past(scl_s))
        else $error("selected module did not see bus clock");

    a_deselect_idle: assert property ( // [RULE_02]
        @(posedge sys_clk) disable iff (rst)
        clk_en && !selected |=> core_lines == 2'b11 && !sda_oe)
        else $error("deselected module saw or drove bus");

    a_select_float: assert property ( // [RULE_03]
        @(posedge sys_clk) disable iff (rst)
        clk_en && !bus_select_driven ##1 clk_en |=> !selected)
        else $error("undriven select read as selected");

    a_held_clears: assert property ( // [RULE_04]
        @(posedge sys_clk) disable iff (rst)
        clk_en && reset_held |=> settings_clear && !attention
        && state == ST_HELD)
        else $error("qualified reset did not clear settings");

    a_release_init: assert property ( // [RULE_05]
        @(posedge sys_clk) disable iff (rst)
        clk_en && state == ST_HELD && reset_release && !reset_held
        |=> state == ST_INIT && timer == '0)
        else $error("interval did not start at release");

    a_ready_posts: assert property ( // [RULE_07]
        @(posedge sys_clk) disable iff (rst)
        clk_en && completion |=> attention_n_oe && !data_not_ready
        ##0 state == ST_READY)
        else $error("completion did not raise attention");

    a_powerup_init: assert property ( // [RULE_08]
        @(posedge sys_clk)
        $fell(rst) |-> state == ST_INIT && timer == '0)
        else $error("power-up did not start interval");

    a_low_power: assert property ( // [RULE_09]
        @(posedge sys_clk) disable iff (rst)
        clk_en && lp_s |=> reduced_power)
        else $error("low-power request not obeyed");

    a_present_low: assert property ( // [RULE_10]
        @(posedge sys_clk) disable iff (rst)
        present_n_oe && !present_n_out)
        else $error("presence line not held low");

    a_fault_sets: assert property ( // [RULE_11]
        @(posedge sys_clk) disable iff (rst)
        clk_en && fault_event && state == ST_READY && !reset_held
        |=> attention_n_oe)
        else $error("fault did not raise attention");

    a_open_drain: assert property ( // [RULE_13]
        @(posedge sys_clk) disable iff (rst)
        !attention_n_out && !sda_out)
        else $error("open-drain output driven high");

    a_flag_readonly: assert property ( // [RULE_15]
        @(posedge sys_clk) disable iff (rst)
        core_write && in_flags |-> !core_write_ok)
        else $error("write into flag field accepted");

    c_completion: cover property (@(posedge sys_clk) disable iff (rst)
        completion);
    c_reset_cycle: cover property (@(posedge sys_clk) disable iff (rst)
        reset_held ##[1:1000] reset_release);
    c_fault_ack: cover property (@(posedge sys_clk) disable iff (rst)
        attention ##1 attention_ack ##1 !attention);
    c_low_power: cover property (@(posedge sys_clk) disable iff (rst)
        reduced_power && selected);

endmodule

/* src/pin_sync.sv */
`timescale 1ns/1ns
// Two flip-flop synchroniser for a group of pin levels.
module pin_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] pins,
    output logic      [W-1:0] synced
);

    // First stage, read only by the second stage.
    logic [W-1:0] meta;

    // ========================================================
    // Two-stage capture
    // ========================================================
    // Both stages load together and freeze with the clock enable.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta   <= RST_VAL;
            synced <= RST_VAL;
        end else if (clk_en) begin
            meta   <= pins;
            synced <= meta;
        end
    end

endmodule

/* src/reset_qualifier.sv */
`timescale 1ns/1ns
// Measures low time on the synchronised reset pin and reports a
// qualified hold and the release that follows it.
module reset_qualifier
    import sideband_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic clk_en,
    input  wire logic level_n,
    output logic      held,
    output logic      released
);

    // Saturating count of low cycles.
    logic [RESET_CNT_W-1:0] low_cnt;

    // The count reaches the least pulse length.
    wire long_enough = (low_cnt >= RESET_CNT_W'(RESET_MIN_CYC - 1));

    // ========================================================
    // Low-time counter
    // ========================================================
    // Counts while low, restarts on every high level.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            low_cnt <= '0;
        end else if (clk_en) begin
            if (level_n) begin
                low_cnt <= '0;
            end else if (!long_enough) begin
                low_cnt <= low_cnt + 1'b1;
            end
        end
    end

    // ========================================================
    // Hold and release
    // ========================================================
    // [RULE_16] short pulses ignored
    // A hold starts only after the full least time; shorter lows
    // vanish without a trace.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            held     <= 1'b0;
            released <= 1'b0;
        end else if (clk_en) begin
            held     <= !level_n && long_enough;
            released <= held && level_n;
        end
    end

    // [RULE_16] short pulses ignored
    a_short_ignored: assert property ( // [RULE_16]
        @(posedge sys_clk) disable iff (rst)
        clk_en && (level_n || !long_enough) |=> !held)
        else $error("hold raised by a short low pulse");

endmodule

/* src/sideband_pkg.sv */
package sideband_pkg;

    // ========================================================
    // Clock and timing
    // ========================================================
    // System clock rate in MHz.
    localparam int CLK_MHZ          = 100;
    // Least low time on the reset pin that counts as a reset, in ns.
    localparam int RESET_MIN_NS     = 10000;
    // Cycles of that least time, rounded up, never below one.
    localparam int RESET_MIN_CYC    =
        ((RESET_MIN_NS * CLK_MHZ + 999) / 1000) < 1 ? 1 :
        ((RESET_MIN_NS * CLK_MHZ + 999) / 1000);
    // Reset execution interval after release, in ms.
    localparam int INIT_MS          = 2000;
    // Cycles of the reset execution interval, an exact product.
    localparam int INIT_CYC         = INIT_MS * CLK_MHZ * 1000;
    // Width of the low-time and interval counters.
    localparam int RESET_CNT_W      = 16;
    localparam int INIT_CNT_W       = 32;

    // ========================================================
    // Management memory layout
    // ========================================================
    // First and last byte of the read-only interrupt flag field.
    localparam logic [7:0] FLAG_FIRST = 8'h03;
    localparam logic [7:0] FLAG_LAST  = 8'h15;

    // ========================================================
    // Reset levels of the pin synchronisers
    // ========================================================
    // Order: select, reset, low power, serial clock, serial data.
    localparam int          PIN_SYNC_W   = 5;
    localparam logic [4:0]  PIN_SYNC_RST = 5'h1b;

    // ========================================================
    // Types
    // ========================================================
    // Two-wire bus levels as seen by the management core.
    typedef struct packed {
        logic scl;
        logic sda;
    } twi_lines_t;

    // Sequencer states of the reset and completion logic.
    typedef enum logic [1:0] {
        ST_INIT  = 2'b00,
        ST_READY = 2'b01,
        ST_HELD  = 2'b10
    } seq_state_t;

endpackage

/* tb/host_model.sv */
`timescale 1ns/1ns
// ========================================================
// Host board controller
// ========================================================
// Models the host side: the pull-ups on the open-drain lines and a
// two-wire bus master whose clock runs only within a frame.
module host_model #(
    parameter int HALF_BIT = 4
) (
    input  wire logic       sys_clk,
    input  wire logic       frame_go,
    input  wire logic [7:0] frame_byte,
    input  wire logic       sda_out,
    input  wire logic       sda_oe,
    input  wire logic       attention_n_out,
    input  wire logic       attention_n_oe,
    input  wire logic       present_n_out,
    input  wire logic       present_n_oe,
    output logic            scl,
    output logic            sda,
    output logic            attention_n,
    output logic            present_n,
    output logic            busy
);
    logic host_sda_low;  // High while the host pulls the data line low.

    assign attention_n = (attention_n_oe && !attention_n_out) ? 1'b0 : 1'b1;
    // The presence line also reads high when nobody pulls it down.
    assign present_n   = (present_n_oe && !present_n_out) ? 1'b0 : 1'b1;
    // The data line is low when either party pulls it, high otherwise.
    assign sda = (host_sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

    // Idle bus: clock stands high and data is released.
    initial begin
        scl          = 1'b1;
        host_sda_low = 1'b0;
        busy         = 1'b0;
    end

    // One frame: start, eight bits sent MSB first, stop.
    // host sends one byte
    always @(posedge frame_go) begin
        busy         = 1'b1;
        host_sda_low = 1'b1;
        repeat (HALF_BIT) @(negedge sys_clk);
        for (int i = 7; i >= 0; i--) begin
            scl          = 1'b0;
            host_sda_low = !frame_byte[i];
            repeat (HALF_BIT) @(negedge sys_clk);
            scl = 1'b1;
            repeat (HALF_BIT) @(negedge sys_clk);
        end
        scl          = 1'b0;
        host_sda_low = 1'b1;
        repeat (HALF_BIT) @(negedge sys_clk);
        scl = 1'b1;
        repeat (HALF_BIT) @(negedge sys_clk);
        host_sda_low = 1'b0;
        busy         = 1'b0;
    end
endmodule

/* tb/tb.sv */
`timescale 1ns/1ns
// ========================================================
// Sideband control testbench
// ========================================================
module tb
    import sideband_pkg::*;
;
    localparam int INIT_N = 20;  // Shortened reset execution interval.

    logic       sys_clk, rst, clk_en, bus_select_n_pin, bus_select_driven;
    logic       module_reset_n, low_power_request, core_sda_low;
    logic       sda_out, sda_oe, core_write, core_write_ok;
    logic       fault_event, attention_ack, attention_n_out, attention_n_oe;
    logic       present_n_out, present_n_oe, reduced_power;
    logic       data_not_ready, settings_clear;
    logic [7:0] core_addr, frame_byte;
    logic [7:0] hist = 8'hff;  // Line levels of the last four cycles.
    twi_lines_t core_lines;
    logic       scl_w, sda_w, attention_n, present_n, busy, frame_go;
    logic [1:0] mode;  // Line watch: 0 off, 1 selected, 2 deselected.
    int         err_total, samples_checked, n;

    module_sideband_control #(.INIT_CYCLES(INIT_N)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
        .bus_select_n_pin(bus_select_n_pin),
        .bus_select_driven(bus_select_driven),
        .module_reset_n(module_reset_n),
        .low_power_request(low_power_request),
        .scl_in(scl_w), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
        .core_sda_low(core_sda_low), .core_lines(core_lines),
        .core_addr(core_addr), .core_write(core_write),
        .core_write_ok(core_write_ok), .fault_event(fault_event),
        .attention_ack(attention_ack), .attention_n_out(attention_n_out),
        .attention_n_oe(attention_n_oe), .present_n_out(present_n_out),
        .present_n_oe(present_n_oe), .reduced_power(reduced_power),
        .data_not_ready(data_not_ready), .settings_clear(settings_clear)
    );

    host_model u_host (
        .sys_clk(sys_clk), .frame_go(frame_go), .frame_byte(frame_byte),
        .sda_out(sda_out), .sda_oe(sda_oe),
        .attention_n_out(attention_n_out), .attention_n_oe(attention_n_oe),
        .present_n_out(present_n_out), .present_n_oe(present_n_oe),
        .scl(scl_w), .sda(sda_w), .attention_n(attention_n),
        .present_n(present_n), .busy(busy)
    );

    // System clock at 100 MHz.
    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;

    // ========================================================
    // Helper tasks
    // ========================================================
    // Counts a comparison and reports a mismatch at once.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic complete_run();
        if (err_total == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Waits a number of falling edges.
    task automatic cyc(input int cnt);
        repeat (cnt) @(negedge sys_clk);
    endtask

    // Waits, bounded, for the attention line to reach a level.
    task automatic wait_att(input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (attention_n !== lvl) begin
            if (cnt >= lim) begin
                err_total++;
                complete_run();
            end
            cyc(1);
            cnt++;
        end
    endtask

    // Has the host model send one frame and waits, bounded, for its end.
    task automatic run_frame(input logic [7:0] b);
        int k;
        frame_byte = b;
        frame_go   = 1'b1;
        cyc(1);
        frame_go = 1'b0;
        k = 0;
        while (busy !== 1'b0) begin
            if (k >= 200) begin
                err_total++;
                complete_run();
            end
            cyc(1);
            k++;
        end
    endtask

    // Compares the lines seen by the core with the pins once settled, or with an idle bus when deselected.
    always @(negedge sys_clk) begin
        if (mode == 2'd1 && hist == {4{hist[1:0]}}) begin
            check(8'(core_lines), 8'(hist[1:0]));
        end
        if (mode == 2'd2) begin
            check(8'(core_lines), 8'h03);
        end
        hist <= {hist[5:0], scl_w, sda_w};
    end

    // ========================================================
    // Main sequence
    // ========================================================
    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        bus_select_n_pin = 1'b1;
        bus_select_driven = 1'b1;
        module_reset_n = 1'b1;
        low_power_request = 1'b0;
        core_sda_low = 1'b0;
        core_addr = 8'h00;
        core_write = 1'b0;
        fault_event = 1'b0;
        attention_ack = 1'b0;
        frame_go = 1'b0;
        frame_byte = 8'h00;
        mode = 2'd0;
        err_total = 0;
        samples_checked = 0;
        cyc(16);
        check(8'(present_n), 8'h00);
        check(8'(attention_n), 8'h01);
        rst = 1'b0;
        // Power-up completion; status is ignored until attention.
        // wait for completion
        wait_att(1'b0, 100, n);
        check(8'(n >= INIT_N), 8'h01);
        check(8'(data_not_ready), 8'h00);
        // Selected: core follows the bus while the host sends the flag address.
        bus_select_n_pin = 1'b0;
        cyc(4);
        mode = 2'd1;
        run_frame(FLAG_FIRST);
        mode = 2'd0;
        core_sda_low = 1'b1;
        cyc(4);
        check(8'(sda_w), 8'h00);
        attention_ack = 1'b1;
        cyc(1);
        attention_ack = 1'b0;
        check(8'(attention_n), 8'h01);
        // Deselected, then select left floating: bus is ignored.
        bus_select_n_pin = 1'b1;
        cyc(4);
        check(8'(sda_oe), 8'h00);
        mode = 2'd2;
        run_frame(8'hc3);
        bus_select_driven = 1'b0;
        bus_select_n_pin  = 1'b0;
        cyc(4);
        check(8'(sda_oe), 8'h00);
        run_frame(8'h3c);
        mode = 2'd0;
        core_sda_low = 1'b0;
        bus_select_driven = 1'b1;
        // Left selected so that low power is also seen while selected.
        bus_select_n_pin  = 1'b0;
        // Low-power request follows the pin after two sync stages and the output register.
        low_power_request = 1'b1;
        cyc(2);
        check(8'(reduced_power), 8'h00);
        cyc(2);
        check(8'(reduced_power), 8'h01);
        low_power_request = 1'b0;
        cyc(4);
        check(8'(reduced_power), 8'h00);
        // With the clock enable low the request must not get through.
        clk_en = 1'b0;
        low_power_request = 1'b1;
        cyc(6);
        check(8'(reduced_power), 8'h00);
        low_power_request = 1'b0;
        clk_en = 1'b1;
        // Writes to the flag field are refused, others accepted.
        core_write = 1'b1;
        for (int a = 0; a < 24; a++) begin
            core_addr = 8'(a);
            cyc(1);
            n = int'(a < FLAG_FIRST || a > FLAG_LAST);
            check(8'(core_write_ok), 8'(n));
        end
        core_write = 1'b0;
        cyc(1);
        check(8'(core_write_ok), 8'h00);
        // Fault raises attention; a fault beats a same-cycle ack.
        fault_event = 1'b1;
        cyc(1);
        fault_event = 1'b0;
        check(8'(attention_n), 8'h00);
        // Clear first, so that the set-over-ack case can be seen.
        attention_ack = 1'b1;
        cyc(1);
        attention_ack = 1'b0;
        check(8'(attention_n), 8'h01);
        cyc(1);
        fault_event   = 1'b1;
        attention_ack = 1'b1;
        cyc(1);
        fault_event   = 1'b0;
        attention_ack = 1'b0;
        check(8'(attention_n), 8'h00);
        // A reset pulse just short of the minimum changes nothing.
        module_reset_n = 1'b0;
        cyc(RESET_MIN_CYC - 10);
        module_reset_n = 1'b1;
        cyc(30);
        check(8'(settings_clear), 8'h00);
        check(8'(attention_n), 8'h00);
        check(8'(data_not_ready), 8'h00);
        // A long reset restores defaults; the interval starts at release.
        module_reset_n = 1'b0;
        cyc(RESET_MIN_CYC + 10);
        check(8'(settings_clear), 8'h01);
        check(8'(data_not_ready), 8'h01);
        check(8'(attention_n), 8'h01);
        cyc(50);
        check(8'(attention_n), 8'h01);
        module_reset_n = 1'b1;
        wait_att(1'b0, 100, n);
        check(8'(n >= INIT_N && n <= INIT_N + 8), 8'h01);
        check(8'(data_not_ready), 8'h00);
        // A second power-up in mid-run posts completion again.
        rst = 1'b1;
        cyc(2);
        check(8'(settings_clear), 8'h01);
        check(8'(attention_n), 8'h01);
        rst = 1'b0;
        wait_att(1'b0, 100, n);
        check(8'(n >= INIT_N), 8'h01);
        check(8'(present_n), 8'h00);
        complete_run();
    end
endmodule
